// ==== rtl/rtccs_defs.svh ====
// constants of the rtc control and status register group
// assumes: included by bare name from every rtl file that needs it
`ifndef RTCCS_DEFS_SVH
`define RTCCS_DEFS_SVH
// two-wire slave address, value is arbitrary
`define RTCCS_SLV_ADDR  7'h5A
// register addresses
`define RTCCS_A_TIME_HI 8'h06
`define RTCCS_A_STATUS  8'h07
`define RTCCS_A_IRQCTL  8'h08
`define RTCCS_A_SUPPLY  8'h09
`define RTCCS_A_BATT    8'h0A
`define RTCCS_A_INITIAL_TRIM_REG    8'h0B
`define RTCCS_A_ALPHA   8'h0C
`define RTCCS_A_BETA    8'h0D
`define RTCCS_A_ALPHAH  8'h2D
// status bit positions
`define RTCCS_ST_BUSY   7
`define RTCCS_ST_OSC    6
`define RTCCS_ST_DST    5
`define RTCCS_ST_TPF    0
// irq_output_control bit positions
`define RTCCS_IC_ACLR   7
`define RTCCS_IC_WREN   6
`define RTCCS_IC_PULSE  5
`define RTCCS_IC_GATE   4
// supply_control clear bit
`define RTCCS_SC_CLR    7
// reset values
`define RTCCS_IRQCTL_RST 8'h01
`define RTCCS_SUPPLY_RST 4'h0
`define RTCCS_BATT_RST   6'h00
// trip code counts: codes at or above have no threshold
`define RTCCS_VDD_CODES 3'h6
`define RTCCS_BAT_CODES 3'h7
// oscillator tick rate (twice the output 32768 Hz) and divider
`define RTCCS_OSC_HZ    65536
`define RTCCS_PULSE_MS  250
`define RTCCS_DIV_W     21
`define RTCCS_FO_SHIFT  5'h05
`endif

// ==== rtl/rtccs_osc_out.sv ====
// oscillator domain: divider chain and open-drain pin drive
// assumes: osc_clk ticks at twice 32768 Hz, controls arrive registered
`timescale 1ns/1ps
`include "rtccs_defs.svh"
module rtccs_osc_out #(
  parameter int PULSE_TICKS = 16384
) (
  // oscillator clock and reset
  input  wire logic                     osc_clk,
  input  wire logic                     nrst,
  // controls from sys_clk domain
  input  wire rtccs_pkg::rtccs_link_type link_i,
  // outputs
  output logic                          pin_low_q,
  output logic                          sec_tick_q
);
  rtccs_pkg::rtccs_link_type ls;          // synchronised controls
  logic                      resync_p_q;  // previous resync toggle
  logic                      alarm_p_q;   // previous alarm toggle
  logic [`RTCCS_DIV_W-1:0]   div_q;       // binary divider chain
  logic [15:0]               pulse_q;     // alarm pulse remaining
  logic                      phase;       // selected clock phase
  logic                      pin_low_d;

  rtccs_sync #(.W($bits(rtccs_pkg::rtccs_link_type))) u_sync (
    .clk   (osc_clk),
    .rst_n (nrst),
    .d     (link_i),
    .q     (ls)
  );

  // toggle history for event detection
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) begin
      resync_p_q <= 1'b0;
      alarm_p_q  <= 1'b0;
    end else begin
      resync_p_q <= ls.resync_tog;
      alarm_p_q  <= ls.alarm_tog;
    end
  end

  // divider restarts on a time write so the second lines up with it
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) div_q <= '0;
    else if (ls.resync_tog != resync_p_q) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end

  // one-second tick when the low sixteen bits wrap
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) sec_tick_q <= 1'b0;
    else sec_tick_q <= (div_q[15:0] == 16'hFFFF);
  end

  // pulse timer, every match restarts it
  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) pulse_q <= 16'h0000;
    else if (ls.alarm_tog != alarm_p_q) pulse_q <= 16'(PULSE_TICKS);
    else if (pulse_q != 16'h0000) pulse_q <= pulse_q - 16'h0001;
  end

  // frequency select decode onto divider taps
  always_comb begin
    case (ls.freq_sel)
      4'h1: phase = div_q[0];
      4'h2: phase = div_q[3];
      4'h3: phase = div_q[5];
      default: phase = div_q[5'(ls.freq_sel) + `RTCCS_FO_SHIFT];
    endcase
  end

  // pin priority: battery gate, then clock, then alarm
  always_comb begin
    if (ls.out_gate) pin_low_d = 1'b0;
    else if (ls.freq_sel != 4'h0) pin_low_d = ~phase;
    else if (ls.pulse_mode) pin_low_d = (pulse_q != 16'h0000);
    else pin_low_d = ls.alarm_level;
  end

  always_ff @(posedge osc_clk or negedge nrst) begin
    if (!nrst) pin_low_q <= 1'b0;
    else pin_low_q <= pin_low_d;
  end
endmodule

// ==== rtl/rtccs_pkg.sv ====
// types shared by the rtc control and status files
// assumes: nothing beyond the language
package rtccs_pkg;
  // two-wire slave sequencer
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_DEV, I2C_DEV_ACK, I2C_REG, I2C_REG_ACK,
    I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
  } rtccs_i2c_type;
  // analog monitor levels, asynchronous to sys_clk
  typedef struct packed {
    logic       temp_busy;
    logic       osc_stopped;
    logic       on_battery;
    logic [5:0] vdd_below;
    logic [6:0] bat1_below;
    logic [6:0] bat2_below;
  } rtccs_mon_type;
  // controls carried into the oscillator domain
  typedef struct packed {
    logic       resync_tog;
    logic       alarm_tog;
    logic       alarm_level;
    logic       pulse_mode;
    logic       out_gate;
    logic [3:0] freq_sel;
  } rtccs_link_type;
endpackage

// ==== rtl/rtccs_sync.sv ====
// two-flop level synchroniser, one stage pair per bit
// assumes: d is a level or a slow toggle, clk is the receiving clock
`timescale 1ns/1ps
module rtccs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q; // first stage, read only by second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          q[i]   <= 1'b0;
        end else begin
          meta_q <= d[i];
          q[i]   <= meta_q;
        end
      end
    end
  endgenerate
endmodule

// ==== rtl/rtccs_top.sv ====
// rtc control and status registers behind a two-wire slave
// assumes: scl/sda and monitor levels are asynchronous, event pulses
// and ext_rdata come from sys_clk logic, osc_clk is the oscillator
`timescale 1ns/1ps
`include "rtccs_defs.svh"
module rtccs_top #(
  parameter int PULSE_TICKS = `RTCCS_OSC_HZ * `RTCCS_PULSE_MS / 1000
) (
  // clocks and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    osc_clk,
  // two-wire bus pins
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  // analog monitors
  input  wire rtccs_pkg::rtccs_mon_type mon_i,
  // events from timekeeping logic
  input  wire logic                    alarm_match_evt,
  input  wire logic                    dst_forward_evt,
  input  wire logic                    dst_reverse_evt,
  input  wire logic                    dst_disable_evt,
  input  wire logic                    total_loss_strap,
  // other register groups
  output logic [7:0]                   ext_addr,
  output logic [7:0]                   ext_wdata,
  output logic                         ext_wr,
  output logic                         ext_rd,
  input  wire logic [7:0]              ext_rdata,
  // timekeeping control
  output logic                         time_run,
  output logic                         stamp_clear,
  output logic                         sec_tick,
  // interrupt / clock pin
  output logic                         irq_clock_out_pin_o,
  output logic                         irq_clock_out_pin_oe
);
  // synchronised pins and monitors
  logic [$bits(rtccs_pkg::rtccs_mon_type)+1:0] sync_q;
  rtccs_pkg::rtccs_mon_type                    mon_s;
  logic                                        scl_s;
  logic                                        sda_s;
  // bus sequencer state
  rtccs_pkg::rtccs_i2c_type state_q;
  logic [3:0]               bit_cnt_q;   // bits seen in this byte
  logic [7:0]               shift_q;     // received byte
  logic [7:0]               tx_q;        // byte being sent
  logic                     rw_q;        // read transfer
  logic                     mack_q;      // master acked last byte
  logic [7:0]               ptr_q;       // register pointer
  logic                     scl_p_q;
  logic                     sda_p_q;
  logic                     sda_oe_q;
  // register contents
  logic [7:0]               irq_q;       // irq_output_control
  logic [3:0]               sup_q;       // supply_control bits 7,2:0
  logic [5:0]               bat_q;       // battery_trip_control
  logic                     osc_q, dst_q, alm_q, low_supply_flag_q, lb1_q, lb2_q, tpf_q;
  logic [3:0]               snap_q;      // flags seen by status read
  logic                     rd_stat_q;   // status read in progress
  logic                     por_done_q;  // strap already caught
  logic                     tw_pend_q;   // time write awaits stop
  logic                     resync_tog_q;
  logic                     alarm_tog_q;
  rtccs_pkg::rtccs_link_type link_q;
  // decoded strobes
  logic       scl_rise, scl_fall, start_det, stop_det, byte_done;
  logic       ld_rd, wr_done, is_local, is_time, blocked;
  logic       wr_time_ok, wr_ext, wst, ac_clr, vdd_trip, b1_trip, b2_trip;
  logic [3:0] clr_vec, set_vec;
  logic [7:0] status_byte, rd_byte;

  // pins and monitors cross into sys_clk through two flops
  // bus pins enter inverted so the flops' zero reset equals the idle-high bus,
  // otherwise a false scl edge would follow every reset
  rtccs_sync #(.W($bits(rtccs_pkg::rtccs_mon_type) + 2)) u_sync (
    .clk   (sys_clk),
    .rst_n (nrst),
    .d     ({~scl_i, ~sda_i, mon_i}),
    .q     (sync_q)
  );
  assign scl_s = ~sync_q[$bits(rtccs_pkg::rtccs_mon_type)+1];
  assign sda_s = ~sync_q[$bits(rtccs_pkg::rtccs_mon_type)];
  assign mon_s = sync_q[$bits(rtccs_pkg::rtccs_mon_type)-1:0];

  // previous bus levels for edge and condition detection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // bus conditions: data moves only while scl is low
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_done = scl_fall & (bit_cnt_q == 4'h8);

  // address classes
  assign is_local = (ptr_q >= `RTCCS_A_STATUS) & (ptr_q <= `RTCCS_A_BATT);
  assign is_time  = (ptr_q <= `RTCCS_A_TIME_HI);
  // trim registers are shut while a conversion runs
  assign blocked  = mon_s.temp_busy & ((ptr_q == `RTCCS_A_INITIAL_TRIM_REG) |
                    (ptr_q == `RTCCS_A_ALPHA) | (ptr_q == `RTCCS_A_BETA) |
                    (ptr_q == `RTCCS_A_ALPHAH));

  // transfer strobes
  assign ld_rd      = scl_fall & rw_q & ((state_q == rtccs_pkg::I2C_DEV_ACK) |
                      ((state_q == rtccs_pkg::I2C_RD_ACK) & mack_q));
  assign wr_done    = byte_done & (state_q == rtccs_pkg::I2C_WR);
  assign wr_time_ok = wr_done & is_time & irq_q[`RTCCS_IC_WREN];
  assign wr_ext     = wr_done & ~is_local & ~blocked &
                      (~is_time | irq_q[`RTCCS_IC_WREN]);
  assign wst        = wr_done & (ptr_q == `RTCCS_A_STATUS);

  // status byte layout, busy is live
  assign status_byte = {mon_s.temp_busy, osc_q, dst_q, alm_q,
                        low_supply_flag_q, lb1_q, lb2_q, tpf_q};

  // read data mux
  always_comb begin
    if (blocked) rd_byte = 8'h00;
    else if (ptr_q == `RTCCS_A_STATUS) rd_byte = status_byte;
    else if (ptr_q == `RTCCS_A_IRQCTL) rd_byte = irq_q;
    else if (ptr_q == `RTCCS_A_SUPPLY) rd_byte = {sup_q[3], 4'h0, sup_q[2:0]};
    else if (ptr_q == `RTCCS_A_BATT) rd_byte = {2'b00, bat_q};
    else rd_byte = ext_rdata;
  end

  // bus sequencer, one byte plus acknowledge per pass
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= rtccs_pkg::I2C_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_det) begin
      // a start always resynchronises, repeated or not
      state_q   <= rtccs_pkg::I2C_DEV;
      bit_cnt_q <= 4'h0;
      rw_q      <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= rtccs_pkg::I2C_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        rtccs_pkg::I2C_DEV, rtccs_pkg::I2C_REG, rtccs_pkg::I2C_WR: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            bit_cnt_q <= 4'h0;
            if (state_q != rtccs_pkg::I2C_DEV) begin
              // register and data bytes are always acknowledged
              state_q  <= (state_q == rtccs_pkg::I2C_REG) ?
                          rtccs_pkg::I2C_REG_ACK : rtccs_pkg::I2C_WR_ACK;
              sda_oe_q <= 1'b1;
            end else if (shift_q[7:1] == `RTCCS_SLV_ADDR) begin
              state_q  <= rtccs_pkg::I2C_DEV_ACK;
              rw_q     <= shift_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              // not ours: stay off the bus until the next start
              state_q <= rtccs_pkg::I2C_IDLE;
            end
          end
        end
        rtccs_pkg::I2C_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q  <= rtccs_pkg::I2C_RD;
              tx_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q  <= rtccs_pkg::I2C_REG;
              sda_oe_q <= 1'b0;
            end
          end
        end
        rtccs_pkg::I2C_REG_ACK, rtccs_pkg::I2C_WR_ACK: begin
          if (scl_fall) begin
            state_q  <= rtccs_pkg::I2C_WR;
            sda_oe_q <= 1'b0;
          end
        end
        rtccs_pkg::I2C_RD: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            state_q   <= rtccs_pkg::I2C_RD_ACK;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_q <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
          end
        end
        rtccs_pkg::I2C_RD_ACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_q) begin
              state_q  <= rtccs_pkg::I2C_RD;
              tx_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q <= rtccs_pkg::I2C_IDLE;
            end
          end
        end
        default: state_q <= rtccs_pkg::I2C_IDLE;
      endcase
    end
  end

  // register pointer: loaded by address byte, steps per data byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ptr_q <= 8'h00;
    else if (byte_done & (state_q == rtccs_pkg::I2C_REG)) ptr_q <= shift_q;
    else if (wr_done | ld_rd) ptr_q <= ptr_q + 8'h01;
  end

  // interrupt control register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) irq_q <= `RTCCS_IRQCTL_RST;
    else if (wr_done & (ptr_q == `RTCCS_A_IRQCTL)) irq_q <= shift_q;
  end

  // supply control and the stamp clear strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sup_q       <= `RTCCS_SUPPLY_RST;
      stamp_clear <= 1'b0;
    end else begin
      stamp_clear <= 1'b0;
      if (wr_done & (ptr_q == `RTCCS_A_SUPPLY)) begin
        sup_q       <= {shift_q[`RTCCS_SC_CLR], shift_q[2:0]};
        stamp_clear <= shift_q[`RTCCS_SC_CLR];
      end
    end
  end

  // battery trip levels
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) bat_q <= `RTCCS_BATT_RST;
    else if (wr_done & (ptr_q == `RTCCS_A_BATT)) bat_q <= shift_q[5:0];
  end

  // comparator select; unused codes never trip
  assign vdd_trip = (sup_q[2:0] < `RTCCS_VDD_CODES) & mon_s.vdd_below[sup_q[2:0]];
  assign b1_trip  = (bat_q[5:3] < `RTCCS_BAT_CODES) & mon_s.bat1_below[bat_q[5:3]];
  assign b2_trip  = (bat_q[2:0] < `RTCCS_BAT_CODES) & mon_s.bat2_below[bat_q[2:0]];

  // auto-clear only removes flags the read actually returned
  assign ac_clr  = stop_det & rd_stat_q & irq_q[`RTCCS_IC_ACLR];
  assign clr_vec = (wst ? ~shift_q[4:1] : 4'h0) | (ac_clr ? snap_q : 4'h0);
  assign set_vec = {alarm_match_evt, vdd_trip, b1_trip, b2_trip};

  // sticky alarm, supply and battery flags; set beats clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) {alm_q, low_supply_flag_q, lb1_q, lb2_q} <= 4'h0;
    else {alm_q, low_supply_flag_q, lb1_q, lb2_q} <= set_vec |
                                          ({alm_q, low_supply_flag_q, lb1_q, lb2_q} & ~clr_vec);
  end

  // snapshot of flags handed out by a status read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      snap_q    <= 4'h0;
      rd_stat_q <= 1'b0;
    end else if (stop_det) begin
      snap_q    <= 4'h0;
      rd_stat_q <= 1'b0;
    end else if (ld_rd & (ptr_q == `RTCCS_A_STATUS)) begin
      snap_q    <= snap_q | {alm_q, low_supply_flag_q, lb1_q, lb2_q};
      rd_stat_q <= 1'b1;
    end
  end

  // oscillator stop flag, cleared by writing zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) osc_q <= 1'b0;
    else osc_q <= mon_s.osc_stopped |
                  (osc_q & ~(wst & ~shift_q[`RTCCS_ST_OSC]));
  end

  // dst adjusted flag; the forward event has priority
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) dst_q <= 1'b0;
    else if (dst_forward_evt) dst_q <= 1'b1;
    else if (dst_reverse_evt | dst_disable_evt) dst_q <= 1'b0;
    else if (wst) dst_q <= shift_q[`RTCCS_ST_DST];
  end

  // power fail flag caught from the strap right after reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      por_done_q <= 1'b0;
      tpf_q      <= 1'b0;
    end else if (!por_done_q) begin
      por_done_q <= 1'b1;
      tpf_q      <= total_loss_strap;
    end else if (wr_time_ok) begin
      tpf_q <= 1'b0;
    end
  end

  // time write completes on stop: run and realign the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tw_pend_q    <= 1'b0;
      time_run     <= 1'b0;
      resync_tog_q <= 1'b0;
    end else if (stop_det & tw_pend_q) begin
      tw_pend_q    <= 1'b0;
      time_run     <= 1'b1;
      resync_tog_q <= ~resync_tog_q;
    end else if (start_det) begin
      tw_pend_q <= 1'b0;
    end else if (wr_time_ok) begin
      tw_pend_q <= 1'b1;
    end
  end

  // alarm events reach the oscillator domain as a toggle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) alarm_tog_q <= 1'b0;
    else if (alarm_match_evt) alarm_tog_q <= ~alarm_tog_q;
  end

  // registered crossing source so no glitch is sampled
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link_q <= '0;
    end else begin
      link_q.resync_tog  <= resync_tog_q;
      link_q.alarm_tog   <= alarm_tog_q;
      link_q.alarm_level <= alm_q;
      link_q.pulse_mode  <= irq_q[`RTCCS_IC_PULSE];
      link_q.out_gate    <= irq_q[`RTCCS_IC_GATE] & mon_s.on_battery;
      link_q.freq_sel    <= irq_q[3:0];
    end
  end

  // external register port follows the pointer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_addr  <= 8'h00;
      ext_wdata <= 8'h00;
      ext_wr    <= 1'b0;
      ext_rd    <= 1'b0;
    end else begin
      ext_addr <= ptr_q;
      ext_wr   <= wr_ext;
      ext_rd   <= ld_rd & ~is_local & ~blocked;
      if (wr_done) ext_wdata <= shift_q;
    end
  end

  // open-drain pins: data is always low, enable pulls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sda_o               <= 1'b0;
      irq_clock_out_pin_o <= 1'b0;
    end else begin
      sda_o               <= 1'b0;
      irq_clock_out_pin_o <= 1'b0;
    end
  end
  assign sda_oe = sda_oe_q;

  rtccs_osc_out #(.PULSE_TICKS(PULSE_TICKS)) u_osc (
    .osc_clk    (osc_clk),
    .nrst       (nrst),
    .link_i     (link_q),
    .pin_low_q  (irq_clock_out_pin_oe),
    .sec_tick_q (sec_tick)
  );
endmodule

// ==== verification/rtccs_chk.sv ====
// assertions on the rtc register group top ports
// assumes: bound into rtccs_top by the statement at the foot
`timescale 1ns/1ps
module rtccs_chk (
  // clocks and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       osc_clk,
  // watched outputs
  input wire logic       sda_o,
  input wire logic [7:0] ext_addr,
  input wire logic       ext_wr,
  input wire logic       ext_rd,
  input wire logic       time_run,
  input wire logic       stamp_clear,
  input wire logic       sec_tick,
  input wire logic       irq_clock_out_pin_o
);
  pin_drive_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !irq_clock_out_pin_o) else $error("pin output not low");
  sda_drive_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sda_o) else $error("data output not low");
  local_addr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ext_wr |-> !(ext_addr inside {8'h07, 8'h08, 8'h09})) else $error("local write leaked");
  stamp_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    stamp_clear |=> !stamp_clear) else $error("stamp clear too long");
  write_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ext_wr |=> !ext_wr) else $error("write strobe too long");
  rd_wr_apart_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(ext_rd && ext_wr)) else $error("read and write together");
  run_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    time_run |=> time_run) else $error("time run dropped");
  tick_pulse_a: assert property (@(posedge osc_clk) disable iff (!nrst)
    sec_tick |=> !sec_tick) else $error("second tick too long");
endmodule
bind rtccs_top rtccs_chk u_chk (.sys_clk, .nrst, .osc_clk, .sda_o, .ext_addr, .ext_wr,
  .ext_rd, .time_run, .stamp_clear, .sec_tick, .irq_clock_out_pin_o);

// ==== verification/rtccs_host.sv ====
// two-wire host model for the rtc register group
// assumes: sda is resolved outside with a pull-up
`timescale 1ns/1ps
`include "rtccs_defs.svh"
module rtccs_host (
  // clock and bus wire
  input  wire logic       clk,
  input  wire logic       sda,
  // driven pins and results
  output logic            scl = 1'b1,
  output logic            sda_low = 1'b0,
  output logic            done = 1'b0,
  output logic [7:0]      rdata = 8'h00
);
  logic smp; // sda seen at scl high
  // third of a bit, well beyond the slave's sync delay
  task automatic hold();
    repeat (8) @(posedge clk);
  endtask
  // one bit, a released bit also samples the slave
  task automatic bit_io(input logic b);
    sda_low <= !b;
    hold();
    scl <= 1'b1;
    hold();
    smp = sda;
    scl <= 1'b0;
    hold();
  endtask
  // start or repeated start: sda falls while scl high
  task automatic start();
    bit_io(1'b1);
    scl <= 1'b1;
    hold();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  // byte msb first, then the ack slot
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i]);
      rdata[i] = smp;
    end
    bit_io(1'b1);
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    xfer({`RTCCS_SLV_ADDR, 1'b0});
    xfer(a);
    xfer(d);
    stop();
  endtask
  // read one byte, master nack, stop ends it
  task automatic rd(input logic [7:0] a);
    start();
    xfer({`RTCCS_SLV_ADDR, 1'b0});
    xfer(a);
    start();
    xfer({`RTCCS_SLV_ADDR, 1'b1});
    xfer(8'hFF);
    stop();
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the rtc register group
// assumes: host model and checker compiled first
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0, osc_clk = 1'b0, nrst = 1'b0;
  logic [3:0] ev = 4'h0; // alarm, dst forward, dst reverse, dst disable pulses
  rtccs_pkg::rtccs_mon_type mon = '0;
  logic scl, sda_low, done, sda_oe, pin_oe, wr, time_run;
  logic [7:0] rdata, wdata, d;
  wire sda = !(sda_low | sda_oe); // pull-up bus
  int num_errors = 0, comparisons = 0, n_wr = 0;
  logic [7:0] exp_q[$]; // expected read bytes
  always #4 sys_clk = ~sys_clk;
  always #3 osc_clk = ~osc_clk;
  rtccs_top #(.PULSE_TICKS(8)) dut (.sys_clk, .nrst, .osc_clk, .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe, .mon_i(mon), .alarm_match_evt(ev[0]), .dst_forward_evt(ev[1]),
    .dst_reverse_evt(ev[2]), .dst_disable_evt(ev[3]), .total_loss_strap(1'b1), .ext_addr(),
    .ext_wdata(wdata), .ext_wr(wr), .ext_rd(), .ext_rdata(8'hA5), .time_run,
    .stamp_clear(), .sec_tick(), .irq_clock_out_pin_o(), .irq_clock_out_pin_oe(pin_oe));
  rtccs_host host (.clk(sys_clk), .sda, .scl, .sda_low, .done, .rdata);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic pin_is(input logic e, input int n);
    repeat (n) @(posedge osc_clk);
    @(negedge osc_clk);
    check({7'h00, pin_oe}, {7'h00, e});
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // read monitor: oldest note against each finished read
  always @(posedge sys_clk) if (done) check(rdata, exp_q.pop_front());
  always @(posedge sys_clk) if (wr) n_wr++;
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(67));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h08, 8'h01);
    rd(8'h07, 8'h01);
    host.wr(8'h00, 8'h12);
    check(8'(n_wr), 8'h00);
    host.wr(8'h09, 8'h85);
    rd(8'h09, 8'h85);
    $display("test reset values done");
    pulse(0);
    host.wr(8'h07, 8'h3F);
    rd(8'h07, 8'h31);
    pulse(2);
    rd(8'h07, 8'h11);
    host.wr(8'h07, 8'h00);
    rd(8'h07, 8'h01);
    pulse(1); // dst enabled long before this event
    rd(8'h07, 8'h21);
    pulse(3);
    rd(8'h07, 8'h01);
    $display("test status flags done");
    host.wr(8'h08, 8'h80);
    mon.vdd_below <= 6'($urandom) | 6'h20;
    mon.bat1_below <= 7'($urandom) | 7'h01;
    mon.bat2_below <= 7'($urandom) | 7'h01;
    repeat (8) @(posedge sys_clk);
    mon <= '0;
    pulse(0);
    pin_is(1'b1, 20);
    rd(8'h07, 8'h1F);
    rd(8'h07, 8'h01);
    pin_is(1'b0, 20);
    $display("test auto clear done");
    host.wr(8'h08, 8'h60);
    pulse(0);
    pin_is(1'b1, 3);
    pin_is(1'b0, 20);
    d = 8'($urandom);
    host.wr(8'h00, d);
    check(wdata, d);
    check({7'h00, time_run}, 8'h01);
    rd(8'h07, 8'h10);
    // trim registers shut while a conversion runs
    mon.temp_busy <= 1'b1;
    host.wr(8'h0C, 8'h3C);
    check(8'(n_wr), 8'h01);
    rd(8'h0B, 8'h00);
    rd(8'h07, 8'h90);
    mon.temp_busy <= 1'b0;
    rd(8'h0B, 8'hA5);
    $display("test pin and time write done");
    // let the read monitor take the last note before the verdict
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule
